// *** src/hbd_host_bus_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - 8080 mode decodes select and strobes
// - 8080 write captured on strobe rising edge
// - 6800 direction pin high reads, low writes
// - low hard_init_n resets all internal logic except the pin synchronisers
// - 8080 drivers enabled only while read low
// - 6800 enable high starts each transfer
// - transfers only while chip select low
module hbd_host_bus_decoder (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       hard_init_n,
  input  wire logic                       mode_6800,
  input  wire logic                       chip_sel_n,
  input  wire logic                       cmd_data_select,
  input  wire logic                       rd_en_pin,
  input  wire logic                       wr_dir_pin,
  input  wire logic [7:0]                 data_in,
  output logic      [7:0]                 data_out,
  output logic                            data_oe,
  input  wire logic [7:0]                 status_val,
  input  wire logic [7:0]                 read_val,
  output hbd_pkg::hbd_xfer_t              xfer_kind,
  output logic                            xfer_pulse,
  output logic      [7:0]                 wr_data,
  output logic                            core_reset
);

  import hbd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation

  logic [HBD_SYNC_W-1:0] pins_s;
  logic [7:0]            data_s;
  logic                  mode_s;
  logic                  cs_n_s;
  logic                  sel_s;
  logic                  rd_s;
  logic                  wr_s;
  logic                  init_n_s;

  hbd_sync #(.W(HBD_SYNC_W)) u_sync_ctl (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in ({hard_init_n, mode_6800, chip_sel_n, cmd_data_select, rd_en_pin, wr_dir_pin}),
    .sync_out (pins_s)
  );

  hbd_sync #(.W(HBD_DATA_W)) u_sync_data (
    .core_clk (core_clk),
    .rst      (rst),
    .async_in (data_in),
    .sync_out (data_s)
  );

  assign {init_n_s, mode_s, cs_n_s, sel_s, rd_s, wr_s} = pins_s;

  ////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    hbd_state_t  state;
    logic        is_write;
    logic        sel;
    logic [7:0]  latch;
    logic [7:0]  dout;
    logic        oe;
    hbd_xfer_t   kind;
    logic        pulse;
    logic [7:0]  wdata;
    logic        creset;
  } hbd_st_t;

  hbd_st_t st_r;
  hbd_st_t st_nxt;

  ////////////////////////////////////////////////////////////////////////////
  // cycle decode from the synchronised pins

  logic      rd_req;
  logic      wr_req;
  hbd_xfer_t req_kind;
  logic      cycle_on;

  always_comb begin
    rd_req   = 1'b0;
    wr_req   = 1'b0;
    req_kind = HBD_XFER_NONE;
    if (!cs_n_s) begin
      if (mode_s) begin
        // enable high opens the cycle; the direction pin picks its sense
        case ({sel_s, wr_s, rd_s})
          3'b011: begin
            rd_req   = 1'b1;
            req_kind = HBD_XFER_STAT_RD;
          end
          3'b111: begin
            rd_req   = 1'b1;
            req_kind = HBD_XFER_DATA_RD;
          end
          3'b001: begin
            wr_req   = 1'b1;
            req_kind = HBD_XFER_PARAM_WR;
          end
          3'b101: begin
            wr_req   = 1'b1;
            req_kind = HBD_XFER_CMD_WR;
          end
          default: begin
            // enable low: no cycle
            rd_req   = 1'b0;
          end
        endcase
      end else begin
        // both strobes low is no legal cycle; reading then is safer than latching a byte blind
        case ({sel_s, rd_s, wr_s})
          3'b000, 3'b001: begin
            rd_req   = 1'b1;
            req_kind = HBD_XFER_STAT_RD;
          end
          3'b100, 3'b101: begin
            rd_req   = 1'b1;
            req_kind = HBD_XFER_DATA_RD;
          end
          3'b010: begin
            wr_req   = 1'b1;
            req_kind = HBD_XFER_PARAM_WR;
          end
          3'b110: begin
            wr_req   = 1'b1;
            req_kind = HBD_XFER_CMD_WR;
          end
          default: begin
            rd_req   = 1'b0;
          end
        endcase
      end
    end
  end

  assign cycle_on = rd_req || wr_req;

  ////////////////////////////////////////////////////////////////////////////
  // access cycle

  always_comb begin
    st_nxt        = st_r;
    st_nxt.pulse  = 1'b0;
    st_nxt.creset = !init_n_s;
    if (!init_n_s) begin
      // hardware init clears everything except the reset indication
      st_nxt        = '0;
      st_nxt.state  = HBD_ST_IDLE;
      st_nxt.kind   = HBD_XFER_NONE;
      st_nxt.latch  = HBD_DATA_RST;
      st_nxt.dout   = HBD_DATA_RST;
      st_nxt.wdata  = HBD_DATA_RST;
      st_nxt.creset = 1'b1;
    end else begin
      case (st_r.state)
        HBD_ST_IDLE: begin
          if (rd_req) begin
            // the byte is taken once as the read opens, so it cannot change under the host
            st_nxt.state    = HBD_ST_ACTIVE;
            st_nxt.sel      = sel_s;
            st_nxt.is_write = 1'b0;
            st_nxt.oe       = 1'b1;
            st_nxt.dout     = sel_s ? read_val : status_val;
            st_nxt.kind     = req_kind;
            st_nxt.pulse    = 1'b1;
          end else if (wr_req) begin
            // a write is reported only when its strobe ends
            st_nxt.state    = HBD_ST_ACTIVE;
            st_nxt.sel      = sel_s;
            st_nxt.is_write = 1'b1;
          end
        end
        HBD_ST_ACTIVE: begin
          // keep sampling the bus; the last value before the strobe ends wins
          st_nxt.latch = data_s;
          if (!cycle_on) begin
            st_nxt.state = HBD_ST_DONE;
            st_nxt.oe    = 1'b0;
            if (st_r.is_write) begin
              st_nxt.wdata = st_r.latch;
              st_nxt.kind  = st_r.sel ? HBD_XFER_CMD_WR : HBD_XFER_PARAM_WR;
              st_nxt.pulse = 1'b1;
            end
          end
        end
        HBD_ST_DONE: begin
          // one idle clock keeps back-to-back strobes apart
          st_nxt.state = HBD_ST_IDLE;
        end
        default: begin
          st_nxt.state = HBD_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r        <= '0;
      st_r.state  <= HBD_ST_IDLE;
      st_r.kind   <= HBD_XFER_NONE;
      st_r.creset <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs straight from the state register

  assign data_out   = st_r.dout;
  assign data_oe    = st_r.oe;
  assign xfer_kind  = st_r.kind;
  assign xfer_pulse = st_r.pulse;
  assign wr_data    = st_r.wdata;
  assign core_reset = st_r.creset;

endmodule : hbd_host_bus_decoder
`default_nettype wire

// *** src/hbd_pkg.sv ***
package hbd_pkg;

  // transfer kinds decoded from the host bus
  typedef enum logic [3:0] {
    HBD_XFER_NONE      = 4'h0,
    HBD_XFER_STAT_RD   = 4'h1,
    HBD_XFER_DATA_RD   = 4'h2,
    HBD_XFER_PARAM_WR  = 4'h4,
    HBD_XFER_CMD_WR    = 4'h8
  } hbd_xfer_t;

  localparam int  HBD_DATA_W     = 8;
  localparam int  HBD_SYNC_W     = 6;
  localparam logic [7:0] HBD_DATA_RST = 8'h00;

  // access-cycle state machine, one-hot
  typedef enum logic [2:0] {
    HBD_ST_IDLE   = 3'b001,
    HBD_ST_ACTIVE = 3'b010,
    HBD_ST_DONE   = 3'b100
  } hbd_state_t;

endpackage : hbd_pkg

// *** src/hbd_sync.sv ***
`timescale 1ns/10ps
`default_nettype none
// two-flop synchroniser for a group of pin levels
module hbd_sync #(
  parameter int W = 1
) (
  input  wire logic         core_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } hbd_sync_st_t;

  hbd_sync_st_t st_r;
  hbd_sync_st_t st_nxt;

  always_comb begin
    st_nxt        = st_r;
    st_nxt.meta   = async_in;
    st_nxt.stable = st_r.meta;
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign sync_out = st_r.stable;

endmodule : hbd_sync
`default_nettype wire

// *** verif/hbd_chk.sv ***
`timescale 1ns/10ps
`default_nettype none
module hbd_chk
  import hbd_pkg::*;
(
  input wire logic       core_clk,
  input wire logic       rst,
  input wire logic       hard_init_n,
  input wire logic       mode_6800,
  input wire logic       chip_sel_n,
  input wire logic       cmd_data_select,
  input wire logic       rd_en_pin,
  input wire logic       wr_dir_pin,
  input wire logic [7:0] data_in,
  input wire logic [7:0] data_out,
  input wire logic       data_oe,
  input wire logic [7:0] status_val,
  input wire logic [7:0] read_val,
  input wire hbd_xfer_t  xfer_kind,
  input wire logic       xfer_pulse,
  input wire logic [7:0] wr_data,
  input wire logic       core_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  oe_read_a: assert property ($rose(data_oe) |-> xfer_pulse && (xfer_kind[0] | xfer_kind[1]))
    else $error("bus driven outside a read");
  rd_byte_a: assert property ($rose(data_oe) |->
    data_out == (xfer_kind[1] ? $past(read_val) : $past(status_val)))
    else $error("wrong read byte");
  sel_dec_a: assert property (xfer_pulse |-> $past(cmd_data_select, 3) == (xfer_kind[1] | xfer_kind[3]))
    else $error("select decoded wrongly");
  cs_gate_a: assert property (xfer_pulse |-> !$past(chip_sel_n, 3))
    else $error("transfer without chip select");
  dir_dec_a: assert property (xfer_pulse && mode_6800 |-> $past(wr_dir_pin, 3) == data_oe)
    else $error("direction decoded wrongly");
  wr_cap_a: assert property (xfer_pulse && !data_oe |-> wr_data == $past(data_in, 4))
    else $error("write byte not captured");
  init_hold_a: assert property (!hard_init_n [*4] |-> core_reset)
    else $error("hardware reset ignored");
  init_quiet_a: assert property (core_reset |-> !xfer_pulse && !data_oe)
    else $error("activity during reset");
  init_rel_a: assert property ($rose(hard_init_n) |-> ##[2:4] !core_reset)
    else $error("reset not released");
  oe_strobe_a: assert property (data_oe |->
    (mode_6800 ? $past(rd_en_pin, 3) : !$past(rd_en_pin, 3)))
    else $error("bus driven without a read strobe");
  en_write_a: assert property (xfer_pulse && mode_6800 && !data_oe |->
    $past(rd_en_pin, 4) && !$past(rd_en_pin, 3))
    else $error("write not taken at enable end");
endmodule : hbd_chk
bind hbd_host_bus_decoder hbd_chk u_chk (.core_clk, .rst, .hard_init_n, .mode_6800, .chip_sel_n,
  .cmd_data_select, .rd_en_pin, .wr_dir_pin, .data_in, .data_out, .data_oe, .status_val, .read_val, .xfer_kind,
  .xfer_pulse, .wr_data, .core_reset);
`default_nettype wire

// *** verif/hbd_host.sv ***
`timescale 1ns/10ps
`default_nettype none
module hbd_host (
  input  wire logic       core_clk,
  input  wire logic       mode_6800,
  input  wire logic [7:0] data_out,
  input  wire logic       data_oe,
  output logic            chip_sel_n,
  output logic            cmd_data_select,
  output logic            rd_en_pin,
  output logic            wr_dir_pin,
  output logic      [7:0] data_in
);
  initial begin
    chip_sel_n = 1'b1;
    cmd_data_select = 1'b0;
    rd_en_pin = 1'b1;
    wr_dir_pin = 1'b1;
    data_in = 8'h00;
  end
  // strobe held 10 clocks, since the device only sees pins through synchronisers
  task cyc(input logic rdq, input logic a, input logic cs, input logic [7:0] d, output logic [7:0] q);
    @(posedge core_clk);
    chip_sel_n <= ~cs;
    cmd_data_select <= a;
    data_in <= rdq ? ~data_in : d;
    rd_en_pin <= ~mode_6800;
    wr_dir_pin <= rdq | ~mode_6800;
    repeat (3) @(posedge core_clk);
    rd_en_pin <= mode_6800 | ~rdq;
    wr_dir_pin <= rdq;
    repeat (10) @(posedge core_clk);
    q = data_oe ? data_out : 8'hzz;
    rd_en_pin <= ~mode_6800;
    wr_dir_pin <= rdq | ~mode_6800;
    repeat (6) @(posedge core_clk);
    chip_sel_n <= 1'b1;
    data_in <= ~data_in; // released bus must not keep the old byte
    repeat (4) @(posedge core_clk);
  endtask : cyc
endmodule : hbd_host
`default_nettype wire

// *** verif/test_host_bus_cycle_decoder.sv ***
`timescale 1ns/10ps
`default_nettype none
module test_host_bus_cycle_decoder;
  import hbd_pkg::*;
  logic       core_clk = 1'b0;
  logic       rst = 1'b1;
  logic       hard_init_n = 1'b1;
  logic       mode_6800 = 1'b0;
  logic       chip_sel_n, cmd_data_select, rd_en_pin, wr_dir_pin, data_oe, xfer_pulse, core_reset;
  logic [7:0] data_in, data_out, wr_data, q;
  logic [7:0] status_val = 8'h00;
  logic [7:0] read_val = 8'h00;
  hbd_xfer_t  xfer_kind;
  int         err_total = 0;
  int         check_count = 0;
  int         cyc_n = 0;
  int         pulse_n = 0;
  always #5 core_clk = ~core_clk;
  hbd_host_bus_decoder uut (.core_clk, .rst, .hard_init_n, .mode_6800, .chip_sel_n, .cmd_data_select,
    .rd_en_pin, .wr_dir_pin, .data_in, .data_out, .data_oe, .status_val, .read_val, .xfer_kind,
    .xfer_pulse, .wr_data, .core_reset);
  hbd_host host (.core_clk, .mode_6800, .data_out, .data_oe, .chip_sel_n, .cmd_data_select,
    .rd_en_pin, .wr_dir_pin, .data_in);
  task chk(input logic [7:0] s, input logic [7:0] e);
    check_count++;
    if (s !== e) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk
  task close_out;
    $display("checks=%0d errors=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : close_out
  //////////////////////////////////////////////////////////////
  task t_mode(input logic m);
    int p0;
    @(posedge core_clk);
    mode_6800 <= m;
    status_val <= {7'h28, m};
    read_val <= {7'h53, ~m};
    for (int k = 0; k < 4; k++) begin
      p0 = pulse_n;
      host.cyc(k < 2, k[0], 1'b1, 8'h3c + 8'(k), q);
      chk({4'h0, xfer_kind}, 8'h01 << k);
      chk(8'(pulse_n - p0), 8'h01);
      if (k < 2) chk(q, k[0] ? {7'h53, ~m} : {7'h28, m});
      else begin
        chk(wr_data, 8'h3c + 8'(k));
        chk(q, 8'hzz);
      end
    end
  endtask : t_mode
  task t_cs;
    int p0;
    p0 = pulse_n;
    host.cyc(1'b0, 1'b0, 1'b0, 8'h99, q);
    host.cyc(1'b1, 1'b0, 1'b0, 8'h00, q);
    chk(q, 8'hzz);
    chk(wr_data, 8'h3f);
    chk({4'h0, xfer_kind}, 8'h08);
    chk(8'(pulse_n - p0), 8'h00);
  endtask : t_cs
  task t_init;
    int p0;
    @(posedge core_clk);
    hard_init_n <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk({3'h0, core_reset, xfer_kind}, 8'h10);
    chk(wr_data, 8'h00);
    hard_init_n <= 1'b1;
    repeat (5) @(posedge core_clk);
    chk({7'h00, core_reset}, 8'h00);
    p0 = pulse_n;
    host.cyc(1'b0, 1'b1, 1'b1, 8'ha5, q);
    chk(wr_data, 8'ha5);
    chk(8'(pulse_n - p0), 8'h01);
  endtask : t_init
  initial begin
    repeat (20) @(posedge core_clk);
    rst <= 1'b0;
    repeat (5) @(posedge core_clk);
    chk({3'h0, core_reset, xfer_kind}, 8'h00);
    t_mode(1'b0);
    t_mode(1'b1);
    t_cs;
    t_init;
    close_out;
  end
  always @(posedge core_clk) begin
    cyc_n <= cyc_n + 1;
    if (xfer_pulse === 1'b1) pulse_n <= pulse_n + 1;
    if (cyc_n == 3000) begin
      err_total++;
      close_out;
    end
  end
endmodule : test_host_bus_cycle_decoder
`default_nettype wire
